//--- ioxc_pkg.sv
// Shared constants, types and state encoding for the I/O expander core
package ioxc_pkg;

    // ************************************************************
    // Bus addressing and register map
    // ************************************************************
    localparam logic [3:0] ADDR_FIXED  = 4'h4;  // Upper address nibble
    localparam logic [2:0] REG_IN0     = 3'h0;
    localparam logic [2:0] REG_IN1     = 3'h1;
    localparam logic [2:0] REG_DRIVE0  = 3'h2;
    localparam logic [2:0] REG_DRIVE1  = 3'h3;
    localparam logic [2:0] REG_INVERT0 = 3'h4;
    localparam logic [2:0] REG_INVERT1 = 3'h5;
    localparam logic [2:0] REG_DIR0    = 3'h6;
    localparam logic [2:0] REG_DIR1    = 3'h7;

    // Register pair codes, pointer bits 2:1
    localparam logic [1:0] PAIR_INPUT  = 2'h0;
    localparam logic [1:0] PAIR_DRIVE  = 2'h1;
    localparam logic [1:0] PAIR_INVERT = 2'h2;
    localparam logic [1:0] PAIR_DIR    = 2'h3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] DRIVE_RST   = 8'hff;
    localparam logic [7:0] INVERT_RST  = 8'h00;
    localparam logic [7:0] DIR_RST     = 8'hff;
    localparam logic [7:0] PTR_RST     = 8'h00;

    // ************************************************************
    // Serial framing and timing
    // ************************************************************
    localparam logic [3:0] BITS_DONE     = 4'h8;  // Bits in one byte
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         INT_VALID_NS  = 4000;  // Interrupt settling
    localparam int         INT_VALID_CYC = (INT_VALID_NS / CLK_PERIOD_NS
                                            < 1) ? 1 :
                                           INT_VALID_NS / CLK_PERIOD_NS;
    localparam logic [15:0] INT_CYC      = 16'(INT_VALID_CYC);
    localparam int         SYNC_W        = 21;    // scl, sda, 3 addr, 16

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK,
        S_WDATA, S_WDATA_ACK, S_RDATA, S_RDATA_ACK
    } ioxc_state_t;

    typedef struct packed {
        logic       en;
        logic [1:0] pair;
        logic       port;
        logic [7:0] data;
    } ioxc_wr_t;

    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] invert;
        logic [7:0] dir;
    } ioxc_cfg_t;

endpackage

//--- ioxc_sync.sv
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/10ps
module ioxc_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // First stage feeds only the second
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= d;
            q_reg    <= meta_reg;
        end
    end

    assign q = q_reg;

endmodule

//--- ioxc_port_bank.sv
// One 8-bit port: drive, invert and direction registers plus change detect
`timescale 1ns/10ps
module ioxc_port_bank #(
    parameter logic PORT_ID = 1'b0
) (
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    input  wire ioxc_pkg::ioxc_wr_t wr,
    input  wire logic               rd_clear,
    input  wire logic [7:0]         pin_lvl,
    output ioxc_pkg::ioxc_cfg_t     cfg,
    output logic      [7:0]         level,
    output logic      [7:0]         pin_out,
    output logic      [7:0]         pin_oe,
    output logic                    change
);
    import ioxc_pkg::*;

    ioxc_cfg_t  cfg_reg;
    ioxc_cfg_t  cfg_next;
    logic [7:0] captured_reg;
    logic [2:0] prime_reg;
    wire        hit = wr.en && (wr.port == PORT_ID);

    // ************************************************************
    // Register writes; input pair writes fall through unused
    // ************************************************************
    assign cfg_next.drive  = (hit && wr.pair == PAIR_DRIVE) ? wr.data
                             : cfg_reg.drive;
    assign cfg_next.invert = (hit && wr.pair == PAIR_INVERT) ? wr.data
                             : cfg_reg.invert;
    assign cfg_next.dir    = (hit && wr.pair == PAIR_DIR) ? wr.data
                             : cfg_reg.dir;

    // Configuration storage
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_reg <= '{drive: DRIVE_RST, invert: INVERT_RST, dir: DIR_RST};
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // Snapshot of pins, refreshed at start-up and on a read clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prime_reg    <= 3'h0;
            captured_reg <= 8'h00;
        end else begin
            prime_reg <= {prime_reg[1:0], 1'b1};
            if (!prime_reg[2] || rd_clear) begin
                captured_reg <= pin_lvl;
            end
        end
    end

    // ************************************************************
    // Pin drive and read view
    // ************************************************************
    assign cfg     = cfg_reg;
    assign level   = pin_lvl ^ cfg_reg.invert;
    assign pin_out = cfg_reg.drive;
    assign pin_oe  = ~cfg_reg.dir;

    // Only input pins compared, so outputs never raise a change
    wire [7:0] diff_in = (pin_lvl ^ captured_reg) & cfg_reg.dir;
    assign change = prime_reg[2] & (|diff_in);

endmodule

//--- ioxc_core.sv
// Register core of a 16-bit I/O expander on a two-wire serial bus
//
// Contract
// - Slave address low three bits come from the address-select pins.
// - Address byte last bit: 1 means read, 0 means write.
// - First byte after a write address is stored in a hidden pointer.
// - Pointer bits 2:0 pick input, drive, invert or direction register.
// - Input registers show sampled pin levels, inputs and outputs alike.
// - Writes to input registers are acknowledged and thrown away.
// - Drive bits set pin level only while the pin is an output.
// - Reading a drive register returns the stored value, not pins.
// - Invert bit 1 flips the level shown in the input register.
// - Direction bit 1 makes the pin an input, 0 an output.
// - Outputs drive high or low actively; inputs have both drivers off.
// - Reset loads register defaults and clears the rest, idling the bus; release starts operation.
// - Any edge on an input pin raises interrupt after a settling delay.
// - Interrupt drops when pins return or the port is read.
// - Read clear happens at acknowledge bit after clock rises.
// - Any later input change after a clear raises interrupt again.
// - Output pins never raise the interrupt.
// - Switching output to input with mismatching level raises interrupt.
// - Successive write bytes alternate between the two pair registers.
// - Read via command and restart; bytes alternate; final byte nacked.
`timescale 1ns/10ps
module ioxc_core (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       addr_sel_bit0,
    input  wire logic       addr_sel_bit1,
    input  wire logic       addr_sel_bit2,
    input  wire logic [7:0] port0_pin_in,
    output logic      [7:0] port0_pin_out,
    output logic      [7:0] port0_pin_oe,
    input  wire logic [7:0] port1_pin_in,
    output logic      [7:0] port1_pin_out,
    output logic      [7:0] port1_pin_oe,
    output logic            int_n_out,
    output logic            int_n_oe
);
    import ioxc_pkg::*;

    localparam int INT_MAX = INT_VALID_CYC + 2;

    // ************************************************************
    // Input synchronisation and bus edge detection
    // ************************************************************
    logic [SYNC_W-1:0] sync_q;
    ioxc_sync #(.W(SYNC_W)) u_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .d       ({scl_in, sda_in, addr_sel_bit2, addr_sel_bit1,
                   addr_sel_bit0, port1_pin_in, port0_pin_in}),
        .q       (sync_q)
    );

    wire       scl_s  = sync_q[20];
    wire       sda_s  = sync_q[19];
    wire [2:0] addr_s = sync_q[18:16];
    wire [7:0] lvl1_s = sync_q[15:8];
    wire [7:0] lvl0_s = sync_q[7:0];

    logic scl_d_reg;
    logic sda_d_reg;

    // Previous line levels for edge finding
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scl_d_reg <= 1'b0;
            sda_d_reg <= 1'b0;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // Start, stop and clock edges
    wire scl_rise  = scl_s & ~scl_d_reg;
    wire scl_fall  = ~scl_s & scl_d_reg;
    wire scl_high  = scl_s & scl_d_reg;
    wire bus_start = scl_high & sda_d_reg & ~sda_s;
    wire bus_stop  = scl_high & ~sda_d_reg & sda_s;

    // ************************************************************
    // State, shift and pointer registers
    // ************************************************************
    ioxc_state_t state_reg, state_next;
    logic [3:0]  bitcnt_reg, bitcnt_next;
    logic [7:0]  shreg_reg, shreg_next;
    logic [7:0]  ptr_reg, ptr_next;
    logic        rw_reg, rw_next;
    logic        drv_reg, drv_next;
    logic        ack_reg, ack_next;
    ioxc_wr_t    wr_req;
    logic [1:0]  rd_clr;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg  <= S_IDLE;
            bitcnt_reg <= 4'h0;
            shreg_reg  <= 8'h00;
            ptr_reg    <= PTR_RST;
            rw_reg     <= 1'b0;
            drv_reg    <= 1'b0;
            ack_reg    <= 1'b0;
        end else begin
            state_reg  <= state_next;
            bitcnt_reg <= bitcnt_next;
            shreg_reg  <= shreg_next;
            ptr_reg    <= ptr_next;
            rw_reg     <= rw_next;
            drv_reg    <= drv_next;
            ack_reg    <= ack_next;
        end
    end

    // ************************************************************
    // Register view and decode
    // ************************************************************
    ioxc_cfg_t  cfg0, cfg1;
    logic [7:0] lvl0, lvl1;
    logic       chg0, chg1;

    wire [7:0][7:0] reg_view = {cfg1.dir, cfg0.dir, cfg1.invert,
                                cfg0.invert, cfg1.drive, cfg0.drive,
                                lvl1, lvl0};
    wire [2:0] ptr_idx  = ptr_reg[2:0];
    wire [2:0] alt_idx  = {ptr_reg[2:1], ~ptr_reg[0]};
    wire [7:0] rd_val   = reg_view[ptr_idx];
    wire [7:0] rd_alt   = reg_view[alt_idx];
    wire [6:0] dev_addr = {ADDR_FIXED, addr_s};
    wire       byte_end = (bitcnt_reg == BITS_DONE);
    wire       in_pair  = (ptr_reg[2:1] == PAIR_INPUT);
    wire [7:0] ptr_tgl  = {ptr_reg[7:3], alt_idx};

    // Serial slave sequencing
    always_comb begin
        state_next  = state_reg;
        bitcnt_next = bitcnt_reg;
        shreg_next  = shreg_reg;
        ptr_next    = ptr_reg;
        rw_next     = rw_reg;
        drv_next    = drv_reg;
        ack_next    = ack_reg;
        wr_req      = '0;
        rd_clr      = 2'b00;
        if (bus_start) begin
            state_next  = S_ADDR;
            bitcnt_next = 4'h0;
            drv_next    = 1'b0;
        end else if (bus_stop) begin
            state_next = S_IDLE;
            drv_next   = 1'b0;
        end else if (scl_rise) begin
            if (state_reg inside {S_ADDR, S_CMD, S_WDATA}) begin
                shreg_next  = {shreg_reg[6:0], sda_s};
                bitcnt_next = bitcnt_reg + 4'h1;
            end else if (state_reg == S_RDATA) begin
                bitcnt_next = bitcnt_reg + 4'h1;
            end else if (state_reg == S_RDATA_ACK) begin
                ack_next = ~sda_s;
                if (in_pair) begin
                    rd_clr[ptr_reg[0]] = 1'b1;
                end
            end
        end else if (scl_fall) begin
            unique case (state_reg)
                S_IDLE: begin
                end
                S_ADDR: begin
                    if (byte_end) begin
                        if (shreg_reg[7:1] == dev_addr) begin
                            state_next = S_ADDR_ACK;
                            drv_next   = 1'b1;
                            rw_next    = shreg_reg[0];
                        end else begin
                            state_next = S_IDLE;
                        end
                    end
                end
                S_ADDR_ACK: begin
                    bitcnt_next = 4'h0;
                    if (rw_reg) begin
                        shreg_next = {rd_val[6:0], 1'b0};
                        drv_next   = ~rd_val[7];
                        state_next = S_RDATA;
                    end else begin
                        drv_next   = 1'b0;
                        state_next = S_CMD;
                    end
                end
                S_CMD: begin
                    if (byte_end) begin
                        ptr_next   = shreg_reg;
                        drv_next   = 1'b1;
                        state_next = S_CMD_ACK;
                    end
                end
                S_CMD_ACK, S_WDATA_ACK: begin
                    drv_next    = 1'b0;
                    bitcnt_next = 4'h0;
                    state_next  = S_WDATA;
                end
                S_WDATA: begin
                    if (byte_end) begin
                        wr_req.en   = 1'b1;
                        wr_req.pair = ptr_reg[2:1];
                        wr_req.port = ptr_reg[0];
                        wr_req.data = shreg_reg;
                        ptr_next    = ptr_tgl;
                        drv_next    = 1'b1;
                        state_next  = S_WDATA_ACK;
                    end
                end
                S_RDATA: begin
                    if (byte_end) begin
                        drv_next   = 1'b0;
                        state_next = S_RDATA_ACK;
                    end else begin
                        drv_next   = ~shreg_reg[7];
                        shreg_next = {shreg_reg[6:0], 1'b0};
                    end
                end
                S_RDATA_ACK: begin
                    ptr_next    = ptr_tgl;
                    bitcnt_next = 4'h0;
                    if (ack_reg) begin
                        shreg_next = {rd_alt[6:0], 1'b0};
                        drv_next   = ~rd_alt[7];
                        state_next = S_RDATA;
                    end else begin
                        drv_next   = 1'b0;
                        state_next = S_IDLE;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Port banks
    // ************************************************************
    ioxc_port_bank #(.PORT_ID(1'b0)) u_bank0 (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .wr       (wr_req),
        .rd_clear (rd_clr[0]),
        .pin_lvl  (lvl0_s),
        .cfg      (cfg0),
        .level    (lvl0),
        .pin_out  (port0_pin_out),
        .pin_oe   (port0_pin_oe),
        .change   (chg0)
    );

    ioxc_port_bank #(.PORT_ID(1'b1)) u_bank1 (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .wr       (wr_req),
        .rd_clear (rd_clr[1]),
        .pin_lvl  (lvl1_s),
        .cfg      (cfg1),
        .level    (lvl1),
        .pin_out  (port1_pin_out),
        .pin_oe   (port1_pin_oe),
        .change   (chg1)
    );

    // ************************************************************
    // Interrupt settling and open-drain output
    // ************************************************************
    wire         mismatch = chg0 | chg1;
    logic [15:0] int_cnt_reg;
    logic        int_reg;
    wire         int_due  = (int_cnt_reg == INT_CYC);

    // Mismatch must persist for the settling time before asserting
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            int_cnt_reg <= 16'h0000;
            int_reg     <= 1'b0;
        end else begin
            int_cnt_reg <= !mismatch ? 16'h0000 :
                           (int_cnt_reg == INT_CYC) ? int_cnt_reg :
                           int_cnt_reg + 16'h0001;
            int_reg     <= mismatch && int_due;
        end
    end

    assign int_n_out = 1'b0;
    assign int_n_oe  = int_reg;
    assign sda_out   = 1'b0;
    assign sda_oe    = drv_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    addr_match_a: assert property (
        state_reg == S_ADDR && scl_fall && byte_end &&
        shreg_reg[7:1] == dev_addr && !bus_start && !bus_stop
        |=> state_reg == S_ADDR_ACK && sda_oe)
        else $error("address match not acknowledged");

    rw_direction_a: assert property (
        state_reg == S_ADDR_ACK && scl_fall && !bus_start && !bus_stop
        |=> (state_reg == S_RDATA) == rw_reg)
        else $error("read/write direction wrong");

    ptr_store_a: assert property (
        state_reg == S_CMD && scl_fall && byte_end && !bus_start
        && !bus_stop |=> ptr_reg == $past(shreg_reg))
        else $error("command byte not stored");

    input_ro_a: assert property (
        wr_req.en && wr_req.pair == PAIR_INPUT
        |=> $stable({cfg0, cfg1}))
        else $error("input register write changed state");

    pin_drive_a: assert property (
        port0_pin_oe == ~cfg0.dir && port1_pin_oe == ~cfg1.dir &&
        port0_pin_out == cfg0.drive && port1_pin_out == cfg1.drive)
        else $error("pin drive does not follow registers");

    int_raise_a: assert property (
        $rose(mismatch) |-> ##[1:INT_MAX] (int_n_oe || !mismatch))
        else $error("interrupt not raised in time");

    int_drop_a: assert property (
        !mismatch |=> !int_n_oe)
        else $error("interrupt held without cause");

    wr_toggle_a: assert property (
        wr_req.en && !bus_start && !bus_stop
        |=> ptr_reg[0] != $past(ptr_reg[0]) &&
            ptr_reg[2:1] == $past(ptr_reg[2:1]))
        else $error("write pointer did not alternate");

    read_byte_c: cover property (
        state_reg == S_RDATA_ACK && scl_fall && ack_reg);
    write_byte_c: cover property (wr_req.en && wr_req.pair == PAIR_DRIVE);
    int_assert_c: cover property ($rose(int_n_oe));
    read_clear_c: cover property (|rd_clr ##1 !mismatch);

endmodule

//--- ioxc_master.sv
// Two-wire bus master model facing the expander core
`timescale 1ns/10ps
module ioxc_master (
    input  wire logic sda_in,
    output logic      scl_low,
    output logic      sda_low
);
    localparam real Q = 31.25;  // Quarter of the 125 ns bus clock

    // Both lines released while idle; the clock stands still
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // Start or repeated start: data falls while the clock is high
    task automatic start();
        sda_low = 1'b0;
        #Q;
        scl_low = 1'b0;
        #Q;
        sda_low = 1'b1;
        #Q;
        scl_low = 1'b1;
        #Q;
    endtask

    // Stop: data rises while the clock is high
    task automatic stop();
        sda_low = 1'b1;
        #Q;
        scl_low = 1'b0;
        #Q;
        sda_low = 1'b0;
        #Q;
    endtask

    // One clock: set data while low, sample in the high phase
    task automatic bit_xfer(input logic b, output logic s);
        sda_low = ~b;
        #Q;
        scl_low = 1'b0;
        #Q;
        s = sda_in;
        #Q;
        scl_low = 1'b1;
        #Q;
    endtask

    // Byte out, most significant bit first, then the slave's ack
    task automatic wbyte(input logic [7:0] b, output logic ak);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], s);
        end
        bit_xfer(1'b1, s);
        ak = ~s;
    endtask

    // Byte in; the final byte of a read is not acknowledged
    task automatic rbyte(output logic [7:0] d, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(last, s);
    endtask
endmodule

//--- ioxc_core_tb.sv
// Self-checking bench for the expander core
`timescale 1ns/10ps
module ioxc_core_tb;
    import ioxc_pkg::*;
    logic       ref_clk, rstn, scl_low, sda_low, ak;
    logic       sda_out, sda_oe, int_n_out, int_n_oe;
    logic [2:0] a_sel;
    logic [7:0] ext0, ext1, p0_out, p0_oe, p1_out, p1_oe;
    logic [7:0] r [8];
    logic [31:0] seed;
    int         n_fail, n_compared;
    wire        sda_w = ~(sda_low | (sda_oe & ~sda_out));

    ioxc_master ioxc_master_inst (.sda_in(sda_w), .scl_low(scl_low),
        .sda_low(sda_low));
    ioxc_core ioxc_core_inst (.ref_clk(ref_clk), .rstn(rstn),
        .scl_in(~scl_low), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_sel_bit0(a_sel[0]),
        .addr_sel_bit1(a_sel[1]), .addr_sel_bit2(a_sel[2]),
        .port0_pin_in((p0_oe & p0_out) | (~p0_oe & ext0)),
        .port0_pin_out(p0_out), .port0_pin_oe(p0_oe),
        .port1_pin_in((p1_oe & p1_out) | (~p1_oe & ext1)),
        .port1_pin_out(p1_out), .port1_pin_oe(p1_oe),
        .int_n_out(int_n_out), .int_n_oe(int_n_oe));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Expectation and checking helpers
    // ************************************************************
    function automatic logic [7:0] nxt();
        repeat (8) seed = {seed[30:0], seed[31]^seed[21]^seed[1]^seed[0]};
        return seed[7:0];
    endfunction

    function automatic logic [7:0] exp_rd(input logic [2:0] i);
        if (i == REG_IN0) return ((~r[6] & r[2]) | (r[6] & ext0)) ^ r[4];
        if (i == REG_IN1) return ((~r[7] & r[3]) | (r[7] & ext1)) ^ r[5];
        return r[i];
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Bounded wait for the interrupt line to reach a level
    task automatic wait_int(input logic v, input int n, input logic want);
        int k;
        k = 0;
        @(negedge ref_clk);
        while (int_n_oe !== v && k < n) begin
            @(negedge ref_clk);
            k++;
        end
        chk({7'h0, int_n_oe === v}, {7'h0, want});
        if (want && int_n_oe !== v) wrap_up();
    endtask

    // ************************************************************
    // Register access over the serial bus
    // ************************************************************
    task automatic wr(input logic [7:0] c, a, b, input logic two);
        ioxc_master_inst.start();
        ioxc_master_inst.wbyte({ADDR_FIXED, a_sel, 1'b0}, ak);
        chk({7'h0, ak}, 8'h01);
        ioxc_master_inst.wbyte(c, ak);
        ioxc_master_inst.wbyte(a, ak);
        if (c[2:1] != PAIR_INPUT) r[c[2:0]] = a;
        if (two) begin
            ioxc_master_inst.wbyte(b, ak);
            if (c[2:1] != PAIR_INPUT) r[c[2:0] ^ 3'h1] = b;
        end
        ioxc_master_inst.stop();
    endtask

    // Read odd register of a pair, then its partner
    task automatic rd(input logic [2:0] c);
        logic [7:0] d;
        ioxc_master_inst.start();
        ioxc_master_inst.wbyte({ADDR_FIXED, a_sel, 1'b0}, ak);
        ioxc_master_inst.wbyte({5'h0, c | 3'h1}, ak);
        ioxc_master_inst.start();
        ioxc_master_inst.wbyte({ADDR_FIXED, a_sel, 1'b1}, ak);
        ioxc_master_inst.rbyte(d, 1'b0);
        chk(d, exp_rd(c | 3'h1));
        ioxc_master_inst.rbyte(d, 1'b1);
        chk(d, exp_rd(c & 3'h6));
        ioxc_master_inst.stop();
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rstn = 1'b0;
        seed = 32'h4bb12d71;
        a_sel = 3'(nxt());
        ext0 = nxt();
        ext1 = nxt();
        r = '{8'h0, 8'h0, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
        repeat (20) @(posedge ref_clk);
        chk(p0_oe | p1_oe, 8'h00);
        chk(p0_out & p1_out, 8'hff);
        @(negedge ref_clk);
        rstn = 1'b1;
        repeat (10) @(negedge ref_clk);
        for (int i = 0; i < 8; i += 2) rd(i);
        // Foreign address must not be acknowledged
        ioxc_master_inst.start();
        ioxc_master_inst.wbyte({ADDR_FIXED, a_sel ^ 3'h1, 1'b0}, ak);
        chk({7'h0, ak}, 8'h00);
        ioxc_master_inst.stop();
        // Random pair writes with readback and pin checks
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 8; i += 2) begin
                @(negedge ref_clk);
                ext0 = nxt();
                ext1 = nxt();
                wr(8'(i + 1), nxt(), nxt(), 1'b1);
                rd(i);
                chk(p0_oe, ~r[6]);
                chk(p1_oe, ~r[7]);
                chk(p0_out & ~r[6], r[2] & ~r[6]);
                chk(p1_out & ~r[7], r[3] & ~r[7]);
            end
        end
        // Interrupt sequence on port 0
        @(negedge ref_clk);
        ext0 = 8'h00;
        wr(8'h6, 8'hfe, 8'h0, 1'b0);
        wr(8'h2, 8'h01, 8'h0, 1'b0);
        rd(0);
        wait_int(1'b0, 20, 1'b1);
        wr(8'h2, 8'h00, 8'h0, 1'b0);
        wait_int(1'b1, 600, 1'b0);
        wr(8'h6, 8'hff, 8'h0, 1'b0);
        wait_int(1'b1, 600, 1'b1);
        rd(0);
        wait_int(1'b0, 20, 1'b1);
        @(negedge ref_clk);
        ext0[3] = 1'b1;
        wait_int(1'b1, 600, 1'b1);
        chk({7'h0, int_n_out}, 8'h00);
        @(negedge ref_clk);
        ext0[3] = 1'b0;
        wait_int(1'b0, 20, 1'b1);
        wrap_up();
    end
endmodule
